// file: adc_fmt_pkg.sv
// constants and types for the converter result formatter and clock control
// Functional notes
// - signed left mode: high byte msb inverted
// - new conversion updates both result bytes
// - high byte read freezes low byte
// - after high read, drop results until low
// - divider code: 1,2,4,8, else 16
// - source select 1 bus clock, 0 crystal
// - reset selects crystal reference clock
// - two-bit justification field picks four placements
// - reset justification is right justified
// - truncated mode: low gets top eight, no lock
// - right mode: high holds bits 9..8
// - left mode: high holds bits 9..2
// - clock register write clears done flag
package adc_fmt_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // printed offsets are word indices; byte address is four times
  localparam logic [ADDR_W-3:0] IDX_RESULT_HIGH = 10'h03d;
  localparam logic [ADDR_W-3:0] IDX_RESULT_LOW  = 10'h03e;
  localparam logic [ADDR_W-3:0] IDX_CLOCK_CTRL  = 10'h03f;
  localparam logic [ADDR_W-3:0] IDX_STATUS      = 10'h040;
  // clock control register fields
  localparam int unsigned DIV_LSB  = 5;
  localparam int unsigned SRC_BIT  = 4;
  localparam int unsigned MODE_LSB = 2;
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h04;
  localparam logic [7:0] CLOCK_CTRL_MASK  = 8'hfc;
  localparam logic [7:0] RESULT_RESET     = 8'h00;
  // status register fields
  localparam int unsigned STAT_DONE_BIT = 7;
  localparam int unsigned STAT_LOCK_BIT = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    JUST_TRUNC8 = 2'h0,
    JUST_RIGHT  = 2'h1,
    JUST_LEFT   = 2'h2,
    JUST_SIGNED = 2'h3
  } just_mode_t;
  typedef enum logic [2:0] {
    BUS_IDLE    = 3'b001,
    BUS_WR_RESP = 3'b010,
    BUS_RD_DATA = 3'b100
  } bus_state_t;
endpackage

// file: adc_fmt_properties.sv
// assertions on the converter and register bus ports of the formatter
`timescale 1ns/1ps
module adc_fmt_properties (
  input wire logic i_sys_clk, i_sys_rst, i_conv_done, o_conversion_done_flag,
  input wire logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready,
  input wire logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready,
  input wire logic o_s_axi_rvalid, i_s_axi_rready
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence rd_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  done_set_a: assert property (i_conv_done |=> o_conversion_done_flag)
    else $error("done flag missed a conversion");
  done_cause_a: assert property ($rose(o_conversion_done_flag) |-> $past(i_conv_done))
    else $error("done flag rose without a conversion");
  wr_resp_a: assert property (wr_taken |=> ##1 o_s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rd_taken |=> o_s_axi_rvalid)
    else $error("read data late");
  b_once_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response repeated");
  r_once_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read data repeated");
  ar_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_arready)
    else $error("read taken during write response");
  aw_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken during read data");
endmodule // adc_fmt_properties
bind adc_result_format_and_clock_ctrl adc_fmt_properties adc_fmt_properties_i (.*);

// file: adc_result_format_and_clock_ctrl.sv
// converter result formatting, read interlock and input clock divider
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adc_result_format_and_clock_ctrl (
  // clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_sys_rst,
  // crystal reference clock pin, sampled
  input  wire logic                          i_crystal_reference_clock,
  // converter core
  input  wire logic                          i_conv_done,
  input  wire logic [9:0]                    i_conv_result,
  output logic                               o_conv_clk_en,
  output logic                               o_conversion_done_flag,
  // axi4-lite write address
  input  wire logic                          i_s_axi_awvalid,
  output logic                               o_s_axi_awready,
  input  wire logic [adc_fmt_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                          i_s_axi_wvalid,
  output logic                               o_s_axi_wready,
  input  wire logic [adc_fmt_pkg::DATA_W-1:0] i_s_axi_wdata,
  input  wire logic [3:0]                    i_s_axi_wstrb,
  // axi4-lite write response
  output logic                               o_s_axi_bvalid,
  input  wire logic                          i_s_axi_bready,
  output logic [1:0]                         o_s_axi_bresp,
  // axi4-lite read address
  input  wire logic                          i_s_axi_arvalid,
  output logic                               o_s_axi_arready,
  input  wire logic [adc_fmt_pkg::ADDR_W-1:0] i_s_axi_araddr,
  // axi4-lite read data
  output logic                               o_s_axi_rvalid,
  input  wire logic                          i_s_axi_rready,
  output logic [adc_fmt_pkg::DATA_W-1:0]     o_s_axi_rdata,
  output logic [1:0]                         o_s_axi_rresp
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    bus_state_t         st;
    logic [ADDR_W-3:0]  wr_idx;
    logic               aw_have;
    logic [7:0]         wr_byte;
    logic               wr_lane0;
    logic               w_have;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         resp;
    logic [7:0]         clk_ctrl;
    logic [7:0]         res_hi;
    logic [7:0]         res_lo;
    logic               locked;
    logic               done;
    logic [2:0]         xsync;
    logic               xlevel;
    logic [3:0]         div_cnt;
    logic [3:0]         div_cfg;
    logic               clk_en;
  } state_t;

  state_t q;
  state_t d;

  // terminal count of the divider for a divide code
  function automatic logic [3:0] div_last(input logic [2:0] code);
    logic [3:0] r;
    r = 4'hf;
    if (!code[2]) begin
      case (code[1:0])
        2'h0:    r = 4'h0;
        2'h1:    r = 4'h1;
        2'h2:    r = 4'h3;
        default: r = 4'h7;
      endcase
    end
    return r;
  endfunction

  function automatic logic [15:0] place(input logic [1:0] m, input logic [9:0] r);
    logic [15:0] v;
    v = 16'h0000;
    case (m)
      JUST_TRUNC8: v = {8'h00, r[9:2]};
      JUST_RIGHT:  v = {6'h00, r[9:8], r[7:0]};
      JUST_LEFT:   v = {r[9:2], r[1:0], 6'h00};
      default:     v = {~r[9], r[8:2], r[1:0], 6'h00};
    endcase
    return v;
  endfunction

  logic [2:0]  div_code;
  logic        src_bus;
  logic [1:0]  mode;
  logic        tick;
  logic        rd_take;
  logic        wr_fire;
  logic [15:0] placed;

  assign div_code = q.clk_ctrl[DIV_LSB +: 3];
  assign src_bus  = q.clk_ctrl[SRC_BIT];
  assign mode     = q.clk_ctrl[MODE_LSB +: 2];
  assign placed   = place(mode, i_conv_result);

  assign o_s_axi_awready = (q.st == BUS_IDLE) && !q.aw_have;
  assign o_s_axi_wready  = (q.st == BUS_IDLE) && !q.w_have;
  // a half-taken write blocks reads so only one access is in flight
  assign o_s_axi_arready = (q.st == BUS_IDLE) && !q.aw_have && !q.w_have;
  assign rd_take         = i_s_axi_arvalid && o_s_axi_arready;
  assign wr_fire         = (q.st == BUS_IDLE) && q.aw_have && q.w_have;

  // bus clock feeds every cycle, the crystal only on its filtered rising edge
  assign tick = src_bus ? 1'b1 : (q.xsync[2] && !q.xlevel && q.xsync[1]);

  always_comb begin
    logic [ADDR_W-3:0] ridx;
    logic              hi_read;
    logic              lo_read;
    logic              clr_done;
    d        = q;
    ridx     = i_s_axi_araddr[ADDR_W-1:2];
    hi_read  = 1'b0;
    lo_read  = 1'b0;
    clr_done = 1'b0;
    d.clk_en = 1'b0;

    // crystal pin synchroniser; a change counts when stages two and three agree
    d.xsync = {q.xsync[1:0], i_crystal_reference_clock};
    if (q.xsync[1] == q.xsync[2]) begin
      d.xlevel = q.xsync[2];
    end

    // divider restarts whenever source or divide code changes
    d.div_cfg = {src_bus, div_code};
    if (q.div_cfg != {src_bus, div_code}) begin
      d.div_cnt = 4'h0;
    end else if (tick) begin
      if (q.div_cnt >= div_last(div_code)) begin
        d.div_cnt = 4'h0;
        d.clk_en  = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 4'h1;
      end
    end

    // capture address and data in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      d.aw_have = 1'b1;
      d.wr_idx  = i_s_axi_awaddr[ADDR_W-1:2];
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      d.w_have   = 1'b1;
      d.wr_byte  = i_s_axi_wdata[7:0];
      d.wr_lane0 = i_s_axi_wstrb[0];
    end

    case (q.st)
      BUS_IDLE: begin
        if (wr_fire) begin
          d.aw_have = 1'b0;
          d.w_have  = 1'b0;
          d.resp    = RESP_OKAY;
          d.st      = BUS_WR_RESP;
          case (q.wr_idx)
            IDX_CLOCK_CTRL: begin
              if (q.wr_lane0) begin
                d.clk_ctrl = q.wr_byte & CLOCK_CTRL_MASK;
              end
              clr_done = 1'b1;
            end
            IDX_RESULT_HIGH, IDX_RESULT_LOW, IDX_STATUS: d.resp = RESP_OKAY;
            default: d.resp = RESP_SLVERR;
          endcase
        end else if (rd_take) begin
          d.rdata = '0;
          d.resp  = RESP_OKAY;
          d.st    = BUS_RD_DATA;
          case (ridx)
            IDX_RESULT_HIGH: begin
              d.rdata[7:0] = q.res_hi;
              hi_read      = 1'b1;
            end
            IDX_RESULT_LOW: begin
              d.rdata[7:0] = q.res_lo;
              lo_read      = 1'b1;
            end
            IDX_CLOCK_CTRL: d.rdata[7:0] = q.clk_ctrl;
            IDX_STATUS: begin
              d.rdata[STAT_DONE_BIT] = q.done;
              d.rdata[STAT_LOCK_BIT] = q.locked;
            end
            default: d.resp = RESP_SLVERR;
          endcase
        end
      end
      BUS_WR_RESP: begin
        if (i_s_axi_bready) begin
          d.st = BUS_IDLE;
        end
      end
      BUS_RD_DATA: begin
        if (i_s_axi_rready) begin
          d.st = BUS_IDLE;
        end
      end
      default: d.st = BUS_IDLE;
    endcase

    // high read holds the low byte until its partner is read
    if (hi_read && mode != JUST_TRUNC8) begin
      d.locked = 1'b1;
    end
    if (lo_read) begin
      d.locked = 1'b0;
      clr_done = 1'b1;
    end
    if (mode == JUST_TRUNC8) begin
      d.locked = 1'b0;
    end

    if (clr_done) begin
      d.done = 1'b0;
    end
    if (i_conv_done) begin
      // the done flag wins over a clear in the same cycle
      d.done = 1'b1;
      if (mode == JUST_TRUNC8) begin
        d.res_hi = RESULT_RESET;
        d.res_lo = placed[7:0];
      end else if (!q.locked && !(hi_read)) begin
        d.res_hi = placed[15:8];
        d.res_lo = placed[7:0];
      end
      // results arriving while locked are dropped
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      q          <= '0;
      q.st       <= BUS_IDLE;
      q.clk_ctrl <= CLOCK_CTRL_RESET;
      q.res_hi   <= RESULT_RESET;
      q.res_lo   <= RESULT_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_conv_clk_en          = q.clk_en;
  assign o_conversion_done_flag = q.done;
  assign o_s_axi_bvalid         = (q.st == BUS_WR_RESP);
  assign o_s_axi_bresp          = q.resp;
  assign o_s_axi_rvalid         = (q.st == BUS_RD_DATA);
  assign o_s_axi_rdata          = q.rdata;
  assign o_s_axi_rresp          = q.resp;
endmodule // adc_result_format_and_clock_ctrl

// file: adc_result_format_and_clock_ctrl_tb_top.sv
// self-checking bench for the result formatter and converter clock divider
`timescale 1ns/1ps
module adc_result_format_and_clock_ctrl_tb_top;
  import adc_fmt_pkg::*;
  logic i_sys_clk = 0, i_sys_rst = 1, i_conv_done = 0, i_crystal_reference_clock;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [9:0] i_conv_result = 0;
  logic [11:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
  logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata, d;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs, wb, md = 2'h1;
  logic o_conv_clk_en, o_conversion_done_flag, o_s_axi_awready, o_s_axi_wready;
  logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, lk = 0;
  logic [2:0] xcnt = 0;
  logic [7:0] mh = 0, ml = 0;
  int num_errors = 0, comparisons = 0, cyc = 0;
  adc_result_format_and_clock_ctrl adc_result_format_and_clock_ctrl_i (.*);
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  // crystal at one eighth of the bus clock, well above the 1 MHz floor
  // the bench scales the 32 kHz to 2 MHz converter clock window up to its own clock
  assign i_crystal_reference_clock = xcnt[2];
  always @(posedge i_sys_clk) begin
    xcnt <= xcnt + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'h0: return {8'h00, r[9:2]};
      2'h1: return {6'h00, r};
      2'h2: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction
  // all bus tasks start and end just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic pa, pw, pb;
    pa = 1;
    pw = 1;
    pb = 1;
    // one edge apart from the previous call, so no signal is driven twice in a step
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= v;
    i_s_axi_awvalid <= 1;
    i_s_axi_wvalid <= 1;
    i_s_axi_bready <= 1;
    while (pa | pw | pb) begin
      @(negedge i_sys_clk);
      if (!pa && !pw && o_s_axi_bvalid === 1'b1) begin
        pb = 0;
        wb = o_s_axi_bresp;
      end
      if (o_s_axi_awready === 1'b1) pa = 0;
      if (o_s_axi_wready === 1'b1) pw = 0;
      @(posedge i_sys_clk);
      i_s_axi_awvalid <= pa;
      i_s_axi_wvalid <= pw;
      i_s_axi_bready <= pb;
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    logic pa, pr;
    pa = 1;
    pr = 1;
    @(posedge i_sys_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1;
    i_s_axi_rready <= 1;
    while (pa | pr) begin
      @(negedge i_sys_clk);
      if (!pa && o_s_axi_rvalid === 1'b1) begin
        pr = 0;
        v = o_s_axi_rdata;
        r = o_s_axi_rresp;
      end
      if (o_s_axi_arready === 1'b1) pa = 0;
      @(posedge i_sys_clk);
      i_s_axi_arvalid <= pa;
      i_s_axi_rready <= pr;
    end
  endtask
  task automatic cv(input logic [9:0] r);
    i_conv_result <= r;
    i_conv_done <= 1;
    if (!lk) {mh, ml} = fmt(md, r);
    @(posedge i_sys_clk);
    i_conv_done <= 0;
    @(posedge i_sys_clk);
  endtask
  task automatic rh();
    rd({IDX_RESULT_HIGH, 2'h0}, d, rs);
    chk(d, {24'h00_0000, mh});
    if (md != 2'h0) lk = 1;
  endtask
  task automatic rl();
    rd({IDX_RESULT_LOW, 2'h0}, d, rs);
    chk(d, {24'h00_0000, ml});
    lk = 0;
  endtask
  task automatic ctl(input logic [1:0] m, input logic [2:0] c, input logic s);
    md = m;
    if (m == 2'h0) lk = 0;
    wr({IDX_CLOCK_CTRL, 2'h0}, {24'h00_0000, c, s, m, 2'h0});
  endtask
  task automatic per(input int n);
    int k;
    k = 0;
    @(negedge i_sys_clk);
    while (o_conv_clk_en !== 1'b1) @(negedge i_sys_clk);
    do begin
      @(negedge i_sys_clk);
      k++;
    end while (o_conv_clk_en !== 1'b1);
    chk(32'(k), 32'(n));
    @(posedge i_sys_clk);
  endtask
  initial begin
    void'($urandom(97315));
    repeat (12) @(posedge i_sys_clk);
    i_sys_rst <= 0;
    @(posedge i_sys_clk);
    rh();
    rl();
    rd({IDX_CLOCK_CTRL, 2'h0}, d, rs);
    chk(d, 32'h0000_0004);
    rd(12'h200, d, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(12'h200, 32'h0000_0000);
    chk(32'(wb), 32'(RESP_SLVERR));
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      ctl(m[1:0], 3'h0, 1'b1);
      chk(32'(wb), 32'(RESP_OKAY));
      cv(10'($urandom));
      rh();
      cv(10'($urandom));
      rl();
      rh();
      rl();
      cv(10'($urandom));
      @(negedge i_sys_clk);
      chk(32'(o_conversion_done_flag), 32'h1);
      rd({IDX_STATUS, 2'h0}, d, rs);
      chk(d, 32'(1) << STAT_DONE_BIT);
      @(posedge i_sys_clk);
      ctl(m[1:0], 3'h0, 1'b1);
      @(negedge i_sys_clk);
      chk(32'(o_conversion_done_flag), 32'h0);
      @(posedge i_sys_clk);
      rh();
      rl();
      $display("test mode %0d done", m);
    end
    for (int c = 0; c < 8; c++) begin
      ctl(2'h1, c[2:0], 1'b1);
      per(c > 3 ? 16 : 1 << c);
    end
    // crystal rises every 8 cycles, so divide by 2 gives 16
    ctl(2'h1, 3'h1, 1'b0);
    per(16);
    $display("test divider done");
    stop_test();
  end
endmodule // adc_result_format_and_clock_ctrl_tb_top
